//--- hdl/omtw_cfg.svh
// Offsets, field positions and timing counts of the module serial master.
`ifndef OMTW_CFG_SVH
`define OMTW_CFG_SVH
`define OMTW_CTL_IDX     11'h79b
`define OMTW_DAT_IDX     11'h79f
`define OMTW_WB_MSB      23
`define OMTW_WB_LSB      16
`define OMTW_CLK_HZ      100000000
`define OMTW_SCL_HZ      100000
`define OMTW_QTR_CYC     ((`OMTW_CLK_HZ / `OMTW_SCL_HZ) / 4)
`define OMTW_QTR_LAST    9'((`OMTW_QTR_CYC) - 1)
`define OMTW_EE_CODE     4'ha
`define OMTW_EE_BANK     3'h0
`define OMTW_RECOV_MAX   4'h9
`define OMTW_LAST_BIT    4'h8
`define OMTW_STEP_DEV_W  2'h0
`define OMTW_STEP_WORD   2'h1
`define OMTW_STEP_SECOND 2'h2
`define OMTW_STEP_RX     2'h3
`define OMTW_PH_LOW0     2'h0
`define OMTW_PH_HIGH0    2'h2
`endif

//--- hdl/omtw_pkg.sv
// Types shared by the module serial master.
package omtw_pkg;
  typedef struct packed {
    logic [5:0]  rsv_hi;
    logic        enable;
    logic        start;
    logic        rsv_b23;
    logic        write_complete;
    logic        rsv_b21;
    logic        read_valid;
    logic [1:0]  rsv_b19;
    logic [1:0]  port;
    logic        dir_read;
    logic [3:0]  target_select_code;
    logic [10:0] location;
  } omtw_ctl_type;

  typedef struct packed {
    logic [10:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } omtw_cpu_req_type;

  typedef enum logic [2:0] {
    OMTW_IDLE,
    OMTW_RECOV,
    OMTW_START,
    OMTW_BITS,
    OMTW_STOP
  } omtw_state_type;
endpackage : omtw_pkg

//--- hdl/omtw_master.sv
// Two-wire master for single-byte access to four pluggable optical modules.
`timescale 1ns/100ps
`include "omtw_cfg.svh"
module omtw_master (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      reset,
  // CPU register port.
  input  wire omtw_pkg::omtw_cpu_req_type cpu_req,
  output logic [31:0]                    cpu_rdata,
  // Module serial link.
  output logic                           scl_out,
  input  wire logic [3:0]                sda_in,
  output logic [3:0]                     sda_out,
  output logic [3:0]                     sda_oe_n
);
  import omtw_pkg::*;

  omtw_ctl_type   ctl_q, ctl_d, job_q, job_d;
  omtw_state_type state_q, state_d;
  logic [7:0]  wbyte_q, wbyte_d, inbound_byte_q, inbound_byte_d, sh_q, sh_d;
  logic [8:0]  qcnt_q, qcnt_d;
  logic [1:0]  phase_q, phase_d, step_q, step_d;
  logic [3:0]  bitn_q, bitn_d, recov_q, recov_d;
  logic        pending_command_q, pending_command_d, drive_q, drive_d, scl_q, scl_d;
  logic [2:0][3:0] sync_q, sync_d;
  logic [3:0]  sda_val_q, sda_val_d;
  logic        sda_sel;
  logic [31:0] rdata_q, rdata_d;
  logic        tick, mid_low, mid_high, busy, ro_space;

  // Device address word: target code, bank bits, direction.
  function automatic logic [7:0] dev_word(input omtw_ctl_type j, input logic rd);
    dev_word = {j.target_select_code, j.location[10:8], rd};
  endfunction : dev_word

  // Register write decode, shared by the field update, the data update and the start deferral.
  function automatic logic reg_hit(input omtw_cpu_req_type r, input logic [10:0] idx);
    reg_hit = r.wr && (r.addr == idx);
  endfunction : reg_hit

  // Quarter-period timebase, 250 cycles at 100 MHz gives a 100 kHz clock.
  always_comb begin
    // Phases zero and one hold the clock low, two and three hold it high.
    tick     = (qcnt_q == `OMTW_QTR_LAST);
    mid_low  = tick && (phase_q == `OMTW_PH_LOW0);
    mid_high = tick && (phase_q == `OMTW_PH_HIGH0);
    if (!ctl_q.enable) begin
      qcnt_d  = '0;
      phase_d = '0;
    end else if (tick) begin
      qcnt_d  = '0;
      phase_d = phase_q + 2'h1;
    end else begin
      qcnt_d  = qcnt_q + 9'h1;
      phase_d = phase_q;
    end
    scl_d = !ctl_q.enable || phase_d[1];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      qcnt_q  <= 9'h000;
      phase_q <= 2'h0;
      scl_q   <= 1'b1;
    end else begin
      qcnt_q  <= qcnt_d;
      phase_q <= phase_d;
      scl_q   <= scl_d;
    end
  end

  // Every data line passes three flops; a level counts once stages two and three agree.
  always_comb begin
    sync_d    = {sync_q[1:0], sda_in};
    sda_val_d = sda_val_q;
    for (int p = 0; p < 4; p++) begin
      if (sync_q[2][p] == sync_q[1][p])
        sda_val_d[p] = sync_q[2][p];
    end
  end

  // The stages start as released lines so that no false start follows reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_q    <= '1;
      sda_val_q <= 4'hf;
    end else begin
      sync_q    <= sync_d;
      sda_val_q <= sda_val_d;
    end
  end

  always_comb begin
    ctl_d             = ctl_q;
    job_d             = job_q;
    state_d           = state_q;
    wbyte_d           = wbyte_q;
    inbound_byte_d    = inbound_byte_q;
    sh_d              = sh_q;
    step_d            = step_q;
    bitn_d            = bitn_q;
    recov_d           = recov_q;
    pending_command_d = pending_command_q;
    drive_d           = drive_q;
    busy              = (state_q != OMTW_IDLE) || pending_command_q;
    ro_space          = (ctl_q.target_select_code == `OMTW_EE_CODE) &&
                        (ctl_q.location[10:8] == `OMTW_EE_BANK);
    sda_sel           = sda_val_q[job_q.port];

    // CPU register writes; status bits stay hardware owned.
    if (reg_hit(cpu_req, `OMTW_CTL_IDX)) begin
      ctl_d.enable             = cpu_req.wdata[25];
      ctl_d.port               = cpu_req.wdata[17:16];
      ctl_d.dir_read           = cpu_req.wdata[15];
      ctl_d.target_select_code = cpu_req.wdata[14:11];
      ctl_d.location           = cpu_req.wdata[10:0];
      if (cpu_req.wdata[24])
        pending_command_d = 1'b1;
    end
    if (reg_hit(cpu_req, `OMTW_DAT_IDX))
      wbyte_d = cpu_req.wdata[`OMTW_WB_MSB:`OMTW_WB_LSB];

    unique case (state_q)
      OMTW_IDLE: begin
        drive_d = 1'b0;
        // A control write in this same cycle defers the take by one cycle.
        if (ctl_q.enable && pending_command_q && !reg_hit(cpu_req, `OMTW_CTL_IDX)) begin
          pending_command_d    = 1'b0;
          ctl_d.read_valid     = 1'b0;
          ctl_d.write_complete = 1'b0;
          job_d                = ctl_q;
          recov_d              = '0;
          if (!ctl_q.dir_read && ro_space)
            ctl_d.write_complete = 1'b1;
          else
            state_d = OMTW_RECOV;
        end
      end
      OMTW_RECOV: begin
        if (mid_high) begin
          recov_d = recov_q + 4'h1;
          // Recovery clocks end as soon as the line is seen released.
          if (sda_sel || recov_d == `OMTW_RECOV_MAX) begin
            state_d = OMTW_START;
            step_d  = `OMTW_STEP_DEV_W;
          end
        end
      end
      OMTW_START: begin
        if (mid_low)
          drive_d = 1'b0;
        else if (mid_high) begin
          drive_d = 1'b1;
          sh_d    = dev_word(job_q, step_q == `OMTW_STEP_SECOND);
          bitn_d  = '0;
          state_d = OMTW_BITS;
        end
      end
      OMTW_BITS: begin
        if (mid_low) begin
          if (step_q == `OMTW_STEP_RX || bitn_q == `OMTW_LAST_BIT)
            drive_d = 1'b0;
          else
            drive_d = !sh_q[7];
        end else if (mid_high) begin
          if (bitn_q != `OMTW_LAST_BIT) begin
            // Each bit is sampled a quarter period after the rising clock edge.
            sh_d   = {sh_q[6:0], sda_sel};
            bitn_d = bitn_q + 4'h1;
          end else begin
            bitn_d = '0;
            if (step_q == `OMTW_STEP_RX) begin
              inbound_byte_d = sh_q;
              state_d        = OMTW_STOP;
            end else if (sda_sel) begin
              // No acknowledge ends the frame early; status still posts.
              state_d = OMTW_STOP;
            end else if (step_q == `OMTW_STEP_DEV_W) begin
              step_d = `OMTW_STEP_WORD;
              sh_d   = job_q.location[7:0];
            end else if (step_q == `OMTW_STEP_WORD) begin
              step_d = `OMTW_STEP_SECOND;
              if (job_q.dir_read)
                state_d = OMTW_START;
              else
                sh_d = wbyte_q;
            end else if (job_q.dir_read) begin
              step_d = `OMTW_STEP_RX;
              sh_d   = '0;
            end else begin
              state_d = OMTW_STOP;
            end
          end
        end
      end
      OMTW_STOP: begin
        if (mid_low)
          drive_d = 1'b1;
        else if (mid_high) begin
          drive_d = 1'b0;
          state_d = OMTW_IDLE;
          if (!pending_command_q) begin
            ctl_d.read_valid     = job_q.dir_read;
            ctl_d.write_complete = !job_q.dir_read;
          end
        end
      end
    endcase

    if (!ctl_q.enable) begin
      state_d = OMTW_IDLE;
      drive_d = 1'b0;
    end

  end

  // Registered read data, one cycle after the read strobe; start reads back as busy.
  always_comb begin
    rdata_d = rdata_q;
    if (cpu_req.rd) begin
      if (cpu_req.addr == `OMTW_CTL_IDX) begin
        rdata_d       = ctl_q;
        rdata_d[24]   = busy;
      end else if (cpu_req.addr == `OMTW_DAT_IDX)
        rdata_d = {8'h00, wbyte_q, 8'h00, inbound_byte_q};
      else
        // Unmapped indexes read back as zero.
        rdata_d = '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q             <= '0;
      job_q             <= '0;
      state_q           <= OMTW_IDLE;
      wbyte_q           <= 8'h00;
      inbound_byte_q    <= 8'h00;
      sh_q              <= 8'h00;
      step_q            <= 2'h0;
      bitn_q            <= 4'h0;
      recov_q           <= 4'h0;
      pending_command_q <= 1'b0;
      drive_q           <= 1'b0;
    end else begin
      ctl_q             <= ctl_d;
      job_q             <= job_d;
      state_q           <= state_d;
      wbyte_q           <= wbyte_d;
      inbound_byte_q    <= inbound_byte_d;
      sh_q              <= sh_d;
      step_q            <= step_d;
      bitn_q            <= bitn_d;
      recov_q           <= recov_d;
      pending_command_q <= pending_command_d;
      drive_q           <= drive_d;
    end
  end

  always_comb begin
    cpu_rdata = rdata_q;
    scl_out   = scl_q;
    sda_out   = 4'h0;
    for (int p = 0; p < 4; p++)
      sda_oe_n[p] = !(drive_q && job_q.port == p[1:0]);
  end
endmodule : omtw_master

//--- verif/omtw_master_properties.sv
// Port checker for the module serial master, bound to its top module.
`timescale 1ns/100ps
`include "omtw_cfg.svh"
module omtw_master_chk (
  // Watched ports.
  input wire logic                       clk,
  input wire logic                       reset,
  input wire omtw_pkg::omtw_cpu_req_type cpu_req,
  input wire logic [31:0]                cpu_rdata,
  input wire logic                       scl_out,
  input wire logic [3:0]                 sda_in,
  input wire logic [3:0]                 sda_out,
  input wire logic [3:0]                 sda_oe_n
);
  import omtw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic        ctl_wr, chg, en_q, en_d, scl_q;
  logic [1:0]  port_q, port_d, tog_q, tog_d;
  logic [15:0] run_q, run_d;
  assign ctl_wr = cpu_req.wr && cpu_req.addr == `OMTW_CTL_IDX;
  assign chg    = scl_out != scl_q;
  // Tracks enable and port from software writes, and clock half-period length.
  always_comb begin
    en_d   = ctl_wr ? cpu_req.wdata[25] : en_q;
    port_d = ctl_wr ? cpu_req.wdata[17:16] : port_q;
    run_d  = chg ? 16'h0 : run_q + 16'h1;
    tog_d  = !en_q ? 2'h0 : (chg && tog_q != 2'h2) ? tog_q + 2'h1 : tog_q;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {en_q, scl_q, port_q, tog_q, run_q} <= '0;
    end else begin
      {en_q, scl_q, port_q, tog_q, run_q} <= {en_d, scl_out, port_d, tog_d, run_d};
    end
  end
  property p_off_idle;
    (!en_q)[*3] |-> scl_out && sda_oe_n == 4'hf;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("serial lines active while disabled");
  property p_half_period;
    chg && en_q && tog_q == 2'h2 |-> run_q >= 16'd499;
  endproperty
  a_half_period: assert property (p_half_period) else $error("serial clock half period too short");
  property p_data_mid;
    $changed(sda_oe_n) && en_q && tog_q == 2'h2 |-> run_q >= 16'd100 && run_q <= 16'd400;
  endproperty
  a_data_mid: assert property (p_data_mid) else $error("data drive moved near a clock edge");
  property p_one_port;
    sda_oe_n != 4'hf |-> sda_oe_n == ~(4'h1 << port_q);
  endproperty
  a_one_port: assert property (p_one_port) else $error("unselected port driven");
  property p_open_drain;
    sda_out == 4'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data output not low");
  property p_new_clears;
    (ctl_wr && cpu_req.wdata[25:24] == 2'h3 && cpu_req.wdata[15]) ##4 (cpu_req.rd && cpu_req.addr == `OMTW_CTL_IDX)
      |=> !cpu_rdata[22] && !cpu_rdata[20];
  endproperty
  a_new_clears: assert property (p_new_clears) else $error("status kept after new access");
  property p_rom_refused;
    ctl_wr && cpu_req.wdata[25:24] == 2'h3 && !cpu_req.wdata[15] && cpu_req.wdata[14:8] == 7'h50
      |=> (&sda_oe_n)[*8];
  endproperty
  a_rom_refused: assert property (p_rom_refused) else $error("write to read-only space drove a line");
  property p_rdata_hold;
    !cpu_req.rd |=> $stable(cpu_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");
endmodule : omtw_master_chk
bind omtw_master omtw_master_chk omtw_master_chk_i (.clk(clk), .reset(reset), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .scl_out(scl_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

//--- verif/omtw_module_model.sv
// Behavioural optical module target on one open-drain data line.
`timescale 1ns/100ps
module omtw_module_model (
  // Serial link.
  input wire logic scl,
  input wire logic sda,
  output logic     pull
);
  logic [7:0] mem [256];
  logic [7:0] sh, wa, rb, last_dev;
  logic       tx = 1'b0;
  logic       rdm = 1'b0;
  logic       live = 1'b0;
  int         cnt = 0;
  int         nb = 0;
  int         wr_cnt = 0;
  initial pull = 1'b0;
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      nb = 0;
      live = 1'b1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      live = 1'b0;
      tx = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (live) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 1;
      if (cnt == 9 && tx && sda) rdm = 1'b0;
      if (cnt == 8 && !tx) begin
        if (nb == 0) begin
          last_dev = sh;
          live = sh[7:4] == 4'ha;
          rdm = sh[0];
          rb = mem[wa];
        end
        if (nb == 1) wa = sh;
        if (nb == 2) begin
          mem[wa] = sh;
          wr_cnt++;
        end
        nb = nb + 1;
      end
    end
  end
  // All drive changes happen while the clock is low, on its falling edge.
  always @(negedge scl) begin
    if (live && cnt == 8 && !tx) begin
      pull = 1'b1;
    end else if (cnt == 9) begin
      cnt = 0;
      tx = rdm && live;
      pull = tx && !rb[7];
    end else begin
      pull = tx && cnt < 8 && !rb[7 - cnt];
    end
  end
endmodule : omtw_module_model

//--- verif/testbench.sv
// Self-checking bench for the module serial master.
`timescale 1ns/100ps
`include "omtw_cfg.svh"
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import omtw_pkg::*;
  logic             clk = 1'b0;
  logic             reset = 1'b1;
  omtw_cpu_req_type cpu_req = '0;
  logic [31:0]      cpu_rdata, rd_v;
  logic             scl_out, pull;
  logic [3:0]       sda_in, sda_out, sda_oe_n;
  int               fail_count = 0;
  int               num_checks = 0;
  always #5 clk = ~clk;
  // Wired-AND lines with pull-ups; the target sits on port 3.
  assign sda_in = ~((~sda_oe_n & ~sda_out) | {pull, 3'b000});
  omtw_master omtw_master_i (.clk(clk), .reset(reset), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .scl_out(scl_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  omtw_module_model omtw_module_model_i (.scl(scl_out), .sda(sda_in[3]), .pull(pull));
  task automatic reg_wr(input logic [10:0] a, input logic [31:0] d);
    @(negedge clk);
    cpu_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    cpu_req.wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [10:0] a);
    @(negedge clk);
    cpu_req.addr = a;
    cpu_req.rd = 1'b1;
    @(negedge clk);
    cpu_req.rd = 1'b0;
    rd_v = cpu_rdata;
  endtask : reg_rd
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    reg_rd(`OMTW_CTL_IDX);
    while (rd_v[b] !== 1'b1 && n < 30000) begin
      reg_rd(`OMTW_CTL_IDX);
      n++;
    end
  endtask : wait_bit
  function automatic logic [31:0] ctl(logic [1:0] p, logic r, logic [10:0] loc);
    return {6'h0, 2'h3, 6'h0, p, r, `OMTW_EE_CODE, loc};
  endfunction : ctl
  task automatic launch(input logic [31:0] w);
    reg_wr(`OMTW_CTL_IDX, w);
    repeat (2) @(negedge clk);
    reg_rd(`OMTW_CTL_IDX);
    `CHECK({rd_v[24], rd_v[22], rd_v[20]}, 3'b100)
  endtask : launch
  task automatic t_regs;
    reg_rd(`OMTW_CTL_IDX);
    `CHECK(rd_v, 32'h0)
    reg_rd(11'h123);
    `CHECK(rd_v, 32'h0)
    $display("register test done");
  endtask : t_regs
  task automatic t_refused;
    reg_wr(`OMTW_CTL_IDX, ctl(2'h3, 1'b0, 11'h010));
    wait_bit(22);
    `CHECK(rd_v[24:20], 5'h04)
    `CHECK(omtw_module_model_i.wr_cnt, 0)
    $display("read-only test done");
  endtask : t_refused
  task automatic t_write;
    reg_wr(`OMTW_DAT_IDX, 32'h005a0000);
    launch(32'h030329ff);
    repeat (4000) @(negedge clk);
    reg_wr(`OMTW_CTL_IDX, ctl(2'h3, 1'b0, 11'h1ff));
    reg_rd(`OMTW_CTL_IDX);
    `CHECK(rd_v[24:20], 5'h10)
    wait_bit(22);
    `CHECK(rd_v[24:20], 5'h04)
    `CHECK(omtw_module_model_i.last_dev, 8'ha2)
    `CHECK(omtw_module_model_i.mem[8'hff], 8'h5a)
    $display("write test done");
  endtask : t_write
  task automatic t_read;
    launch(ctl(2'h3, 1'b1, 11'h1ff));
    wait_bit(20);
    `CHECK(rd_v[24:20], 5'h01)
    `CHECK(omtw_module_model_i.last_dev, 8'ha3)
    reg_rd(`OMTW_DAT_IDX);
    `CHECK(rd_v, 32'h005a005a)
    $display("read test done");
  endtask : t_read
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_refused();
    t_write();
    t_read();
    test_done();
  end
  initial begin
    #950000;
    fail_count++;
    test_done();
  end
endmodule : testbench
